/* hdl/tomr_defines.vh */
// register offset, field positions and reset value of the operating mode register
// assumes inclusion by bare name from design files
`ifndef TOMR_DEFINES_VH
`define TOMR_DEFINES_VH
`define TOMR_ADDR_W 8
`define TOMR_OPMODE_ADDR 8'h0b
`define TOMR_OPMODE_RESET 8'h80
`define TOMR_BIT_POWER_DOWN_BIT 7
`define TOMR_AMODE_HI 6
`define TOMR_AMODE_LO 5
`define TOMR_BIT_WINDOW 4
`define TOMR_BIT_FILT 3
`define TOMR_BIT_AVG_POS 2
`define TOMR_BIT_AVG_PRS 1
`define TOMR_MODE_DIRECT 2'h0
`define TOMR_MODE_XY 2'h1
`define TOMR_MODE_XYZ1 2'h2
`define TOMR_MODE_XYZ12 2'h3
`endif

/* hdl/tomr_opmode_reg.v */
// operating mode configuration register of the touch controller core
// assumes the serial link decoder presents one-cycle write/read strobes on mclk
`timescale 1ns/1ps
`default_nettype none
`include "tomr_defines.vh"

module tomr_opmode_reg (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // register access from serial link decoder
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // control outputs to the core
  output wire power_down_bit,
  output wire otp_reset,
  output wire [1:0] acquisition_mode_field,
  output wire self_scan,
  output wire scan_x,
  output wire scan_y,
  output wire scan_first_pressure_term,
  output wire scan_second_pressure_term,
  output wire spatial_window_enable,
  output wire aperture_active,
  output wire filter_type_select,
  output wire median_filter,
  output wire position_averaging_enable,
  output wire pressure_averaging_enable,
  output wire aux_allowed,
  output reg fifo_clear,
  output reg meas_clear
);

  reg [7:0] opmode_q;
  reg [7:0] opmode_d;
  wire hit_wr;
  wire [3:0] scan_set_d;
  reg [3:0] scan_set_q;
  reg aperture_q;
  reg aux_q;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // address match, shared by the write and read paths
  function tomr_addr_hit;
    input [7:0] addr;
    begin
      tomr_addr_hit = (addr == `TOMR_OPMODE_ADDR);
    end
  endfunction

  // scan set {x, y, first pressure, second pressure} for a mode code
  // a powered-down device scans nothing, whatever the mode field holds
  function [3:0] tomr_scan_set;
    input pwr_dn;
    input [1:0] mode;
    begin
      if (pwr_dn) begin
        tomr_scan_set = 4'h0;
      end else begin
        case (mode)
          `TOMR_MODE_DIRECT: tomr_scan_set = 4'h0;
          `TOMR_MODE_XY: tomr_scan_set = 4'hc;
          `TOMR_MODE_XYZ1: tomr_scan_set = 4'he;
          default: tomr_scan_set = 4'hf;
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // write path

  assign hit_wr = reg_wr && tomr_addr_hit(reg_addr);

  always @* begin
    opmode_d = opmode_q;
    if (hit_wr) begin
      // reserved bit kept zero whatever the host writes
      opmode_d = {reg_wdata[7:1], 1'b0};
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      opmode_q <= `TOMR_OPMODE_RESET;
      fifo_clear <= 1'b0;
      meas_clear <= 1'b0;
    end else begin
      opmode_q <= opmode_d;
      // pulse fires on every write to this register's address, even an unchanged value
      fifo_clear <= hit_wr;
      meas_clear <= hit_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: registered data, zero for other addresses

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (tomr_addr_hit(reg_addr)) begin
        reg_rdata <= opmode_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered scan decode
  // decoded from the next register value so the flops move on the same
  // edge as the register itself; no extra cycle of latency

  assign scan_set_d = tomr_scan_set(opmode_d[`TOMR_BIT_POWER_DOWN_BIT],
                                    opmode_d[`TOMR_AMODE_HI:`TOMR_AMODE_LO]);

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // reset value is powered down, so nothing scans
      scan_set_q <= 4'h0;
      aperture_q <= 1'b0;
      aux_q <= 1'b0;
    end else begin
      scan_set_q <= scan_set_d;
      // aperture gates fifo logging only in autonomous scanning
      aperture_q <= opmode_d[`TOMR_BIT_WINDOW] && (scan_set_d != 4'h0);
      // advisory only; the host is expected to respect it
      aux_q <= !opmode_d[`TOMR_BIT_POWER_DOWN_BIT] &&
               (opmode_d[`TOMR_AMODE_HI:`TOMR_AMODE_LO] == `TOMR_MODE_DIRECT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field outputs

  assign power_down_bit = opmode_q[`TOMR_BIT_POWER_DOWN_BIT];
  assign otp_reset = opmode_q[`TOMR_BIT_POWER_DOWN_BIT];
  assign acquisition_mode_field = opmode_q[`TOMR_AMODE_HI:`TOMR_AMODE_LO];
  // every autonomous mode scans x, so x doubles as the self-scan flag
  assign self_scan = scan_set_q[3];
  assign scan_x = scan_set_q[3];
  assign scan_y = scan_set_q[2];
  assign scan_first_pressure_term = scan_set_q[1];
  assign scan_second_pressure_term = scan_set_q[0];
  assign spatial_window_enable = opmode_q[`TOMR_BIT_WINDOW];
  assign aperture_active = aperture_q;
  assign filter_type_select = opmode_q[`TOMR_BIT_FILT];
  assign median_filter = !filter_type_select;
  assign position_averaging_enable = opmode_q[`TOMR_BIT_AVG_POS];
  assign pressure_averaging_enable = opmode_q[`TOMR_BIT_AVG_PRS];
  assign aux_allowed = aux_q;

endmodule
`default_nettype wire

/* tb/tomr_host.sv */
// host model: register writes and reads over the strobes
// assumes strobes sampled on rising mclk
`timescale 1ns/1ps
`default_nettype none
module tomr_host (input wire logic mclk, input wire logic [7:0] reg_rdata,
  output logic reg_wr = 1'b0, reg_rd = 1'b0, output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00);
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk) {reg_wr, reg_wdata} <= {1'b0, ~d}; // data not held once released
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* tb/tomr_opmode_reg_properties.sv */
// checker: clear pulses and mode decodes
// assumes bind onto tomr_opmode_reg
`timescale 1ns/1ps
`default_nettype none
module tomr_props (input wire logic mclk, rst_b, reg_wr, power_down_bit, otp_reset, self_scan,
  scan_second_pressure_term, aperture_active, spatial_window_enable, fifo_clear, meas_clear,
  input wire logic [7:0] reg_addr, input wire logic [1:0] acquisition_mode_field);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence hit; reg_wr && reg_addr == 8'h0b; endsequence
  clr_pulse_a: assert property (hit |=> fifo_clear && meas_clear) else $error("no clear");
  no_clr_a: assert property (!(reg_wr && reg_addr == 8'h0b) |=> !fifo_clear)
    else $error("stray clear");
  otp_pd_a: assert property (otp_reset == power_down_bit) else $error("otp");
  pd_idle_a: assert property (power_down_bit |-> !self_scan) else $error("pd");
  direct_a: assert property (acquisition_mode_field == 2'h0 |-> !self_scan) else $error("d");
  auto_a: assert property (!power_down_bit && |acquisition_mode_field |-> self_scan)
    else $error("auto");
  both_z_a: assert property (scan_second_pressure_term == (self_scan && &acquisition_mode_field))
    else $error("z");
  spatial_window_enable_a: assert property (aperture_active == (spatial_window_enable && self_scan))
    else $error("ap");
endmodule
bind tomr_opmode_reg tomr_props u_props (.*);
`default_nettype wire

/* tb/tomr_opmode_reg_bench.sv */
// bench: mode register reads, writes, decodes and clears
// assumes host model drives the strobes
`timescale 1ns/1ps
`default_nettype none
module tomr_opmode_reg_bench;
  logic mclk = 1'b0, rst_b = 1'b0, wr, rd, ss, z1, z2, ap, pd, fc, mc;
  logic otp, sx, sy, swe, fts, mf, pae, pre, aux;
  logic [1:0] am;
  logic [7:0] a, wd, rdat, q, p;
  int n_errors = 0, check_count = 0;
  always #10 mclk = ~mclk;
  tomr_host u_host (.mclk, .reg_wr(wr), .reg_rd(rd), .reg_addr(a), .reg_wdata(wd), .reg_rdata(rdat));
  tomr_opmode_reg u_dut (.mclk, .rst_b, .reg_wr(wr), .reg_rd(rd), .reg_addr(a), .reg_wdata(wd),
    .reg_rdata(rdat), .power_down_bit(pd), .otp_reset(otp), .acquisition_mode_field(am),
    .self_scan(ss), .scan_x(sx), .scan_y(sy), .scan_first_pressure_term(z1),
    .scan_second_pressure_term(z2), .spatial_window_enable(swe), .aperture_active(ap),
    .filter_type_select(fts), .median_filter(mf), .position_averaging_enable(pae),
    .pressure_averaging_enable(pre), .aux_allowed(aux),
    .fifo_clear(fc), .meas_clear(mc));
  task chk(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000 n_errors++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    u_host.rd(8'h0b, q);
    chk(q, 8'h80);
    chk({pd, otp, ss, mf, aux, fc, mc, 1'b0}, 8'hd0);
    for (int m = 0; m < 4; m++) begin
      p = {1'b0, m[1:0], ~m[1], m[0], m[1], ~m[0], 1'b0};
      u_host.wr(8'h0b, p);
      #1 chk({6'h00, fc, mc}, 8'h03);
      chk({4'h0, ss, z1, z2, ap}, {4'h0, m != 0, m[1], m == 3, m == 1});
      chk({am, swe, fts, pae, pre, sx, sy}, {m[1:0], ~m[1], m[0], m[1], ~m[0], m != 0, m != 0});
      chk({5'h00, mf, aux, otp}, {5'h00, ~m[0], m == 0, 1'b0});
      u_host.rd(8'h0b, q);
      chk(q, p);
    end
    $display("mode test done");
    u_host.wr(8'h0b, 8'hff);
    u_host.rd(8'h0b, q);
    chk(q, 8'hfe);
    chk({5'h00, pd, otp, ss}, 8'h06);
    u_host.wr(8'h0a, 8'h00);
    #1 chk({6'h00, fc, mc}, 8'h00);
    u_host.rd(8'h0a, q);
    chk(q, 8'h00);
    u_host.rd(8'h0b, q);
    chk(q, 8'hfe);
    $display("power down and unmapped test done");
    close_out;
  end
endmodule
`default_nettype wire
